/* hw/tlic_arbiter.sv */
module tlic_arbiter (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic [tlic_pkg::NUM_SLOTS-1:0] pend,
    input  wire logic [tlic_pkg::NUM_SLOTS-1:0] enable,
    input  wire logic [tlic_pkg::NUM_SLOTS-1:0] prio,
    input  wire logic                         global_irq_enable,
    input  wire logic                         act_lo,
    input  wire logic                         act_hi,
    output logic                              win_valid_r,
    output logic [tlic_pkg::SLOT_W-1:0]       win_slot_r,
    output logic                              win_high_r
);

    // Lowest set index wins among equal levels.
    function automatic logic [tlic_pkg::SLOT_W-1:0] first_set(
        input logic [tlic_pkg::NUM_SLOTS-1:0] v);
        logic [tlic_pkg::SLOT_W-1:0] idx;
        idx = '0;
        for (int i = tlic_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = tlic_pkg::SLOT_W'(i);
            end
        end
        return idx;
    endfunction

    logic [tlic_pkg::NUM_SLOTS-1:0] req;
    logic [tlic_pkg::NUM_SLOTS-1:0] req_hi;
    logic [tlic_pkg::NUM_SLOTS-1:0] req_lo;
    logic                           allow_hi;
    logic                           allow_lo;
    logic                           any_hi;
    logic                           any_lo;

    assign req      = pend & enable & tlic_pkg::SRC_MAP
                      & {tlic_pkg::NUM_SLOTS{global_irq_enable}};
    assign req_hi   = req & prio;
    assign req_lo   = req & ~prio;
    assign allow_hi = !act_hi;
    assign allow_lo = !act_hi && !act_lo;
    assign any_hi   = allow_hi && (|req_hi);
    assign any_lo   = allow_lo && (|req_lo);

    // Requests are sampled and decoded on every clock: this is the detect cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_valid_r <= 1'b0;
            win_slot_r  <= '0;
            win_high_r  <= 1'b0;
        end else begin
            win_valid_r <= any_hi || any_lo;
            win_slot_r  <= any_hi ? first_set(req_hi) : first_set(req_lo);
            win_high_r  <= any_hi;
        end
    end

endmodule

/* hw/tlic_ctrl.sv */
// Implementation choices: the register offsets and the address-and-strobe port.
module tlic_ctrl (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic [tlic_pkg::NUM_SLOTS-1:0] src_event,
    input  wire logic                           instr_done,
    input  wire logic                           return_from_service,
    input  wire logic                           core_stall,
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [31:0]                         reg_rdata,
    output logic                                call_busy,
    output logic                                long_call_instr,
    output logic [15:0]                         call_vector,
    output logic                                call_level,
    output logic                                irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam int N = tlic_pkg::NUM_SLOTS;

    logic                    global_irq_enable_r;
    logic [N-1:0]            enable_r;
    logic [N-1:0]            prio_r;
    logic [N-1:0]            pend_r;
    logic [N-1:0]            pend_nxt;
    logic [2:0]              evt_r;
    logic [2:0]              evt_nxt;
    logic [2:0]              evmask_r;
    tlic_pkg::tlic_state_t   state_r;
    tlic_pkg::tlic_state_t   state_nxt;
    logic [2:0]              cnt_r;
    logic [2:0]              cnt_nxt;
    logic                    act_lo_r;
    logic                    act_hi_r;
    logic                    act_lo_nxt;
    logic                    act_hi_nxt;
    logic [15:0]             vec_r;
    logic                    lvl_r;
    logic                    long_call_instr_r;
    logic [4:0]              cur_slot_r;
    logic [7:0]              wait_r;
    logic [7:0]              lat_r;
    logic [31:0]             rdata_r;

    logic                    win_valid;
    logic [4:0]              win_slot;
    logic                    win_high;

    ////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic         sel_ctrl;
    logic         sel_enable;
    logic         sel_prio;
    logic         sel_pend;
    logic         sel_state;
    logic         sel_evt;
    logic         sel_evmask;
    logic         sel_lat;
    logic         wr_ctrl;
    logic         wr_enable;
    logic         wr_prio;
    logic         wr_pend;
    logic         wr_evt;
    logic         wr_evmask;
    logic [N-1:0] wdata_slots;

    assign sel_ctrl    = reg_addr == tlic_pkg::OFS_CTRL;
    assign sel_enable  = reg_addr == tlic_pkg::OFS_ENABLE;
    assign sel_prio    = reg_addr == tlic_pkg::OFS_PRIO;
    assign sel_pend    = reg_addr == tlic_pkg::OFS_PEND;
    assign sel_state   = reg_addr == tlic_pkg::OFS_STATE;
    assign sel_evt     = reg_addr == tlic_pkg::OFS_EVT;
    assign sel_evmask  = reg_addr == tlic_pkg::OFS_EVMASK;
    assign sel_lat     = reg_addr == tlic_pkg::OFS_LAT;
    assign wr_ctrl     = reg_wr && sel_ctrl;
    assign wr_enable   = reg_wr && sel_enable;
    assign wr_prio     = reg_wr && sel_prio;
    assign wr_pend     = reg_wr && sel_pend;
    assign wr_evt      = reg_wr && sel_evt;
    assign wr_evmask   = reg_wr && sel_evmask;
    assign wdata_slots = reg_wdata[N-1:0] & tlic_pkg::SRC_MAP;

    ////////////////////////////////////////////////////////////////////////
    // Arbitration.

    tlic_arbiter u_arb (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .pend              (pend_r),
        .enable            (enable_r),
        .prio              (prio_r),
        .global_irq_enable (global_irq_enable_r),
        .act_lo            (act_lo_nxt),
        .act_hi            (act_hi_nxt),
        .win_valid_r       (win_valid),
        .win_slot_r        (win_slot),
        .win_high_r        (win_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Call sequencing.

    logic         boundary;
    logic         take;
    logic         call_end;
    logic         ret_now;
    logic [N-1:0] hw_clr;
    logic [15:0]  win_vector;

    // An instruction boundary only counts while the core is not stalled.
    assign boundary   = instr_done && !core_stall;
    assign ret_now    = return_from_service && !core_stall;
    assign take       = win_valid && boundary && !ret_now
                        && (state_r != tlic_pkg::ST_CALL);
    assign call_end   = (state_r == tlic_pkg::ST_CALL)
                        && (cnt_r == 3'(tlic_pkg::CALL_CYCLES - 1)) && !core_stall;
    assign win_vector = tlic_pkg::VEC_BASE
                        + (16'(win_slot) << tlic_pkg::VEC_SHIFT);
    assign hw_clr     = take ? (tlic_pkg::HW_CLEAR_MAP & (19'h00001 << win_slot))
                             : '0;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            tlic_pkg::ST_IDLE: begin
                if (take) begin
                    state_nxt = tlic_pkg::ST_CALL;
                    cnt_nxt   = '0;
                end else if (ret_now) begin
                    state_nxt = tlic_pkg::ST_RETH;
                end
            end
            tlic_pkg::ST_CALL: begin
                if (call_end) begin
                    state_nxt = tlic_pkg::ST_IDLE;
                end else if (!core_stall) begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            tlic_pkg::ST_RETH: begin
                // The instruction after a return always completes first.
                if (take) begin
                    state_nxt = tlic_pkg::ST_CALL;
                    cnt_nxt   = '0;
                end else if (boundary) begin
                    state_nxt = tlic_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = tlic_pkg::ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    // Active levels: set on the call, the higher released first on return.
    always_comb begin
        act_lo_nxt = act_lo_r;
        act_hi_nxt = act_hi_r;
        if (ret_now) begin
            if (act_hi_r) begin
                act_hi_nxt = 1'b0;
            end else begin
                act_lo_nxt = 1'b0;
            end
        end
        if (take) begin
            if (win_high) begin
                act_hi_nxt = 1'b1;
            end else begin
                act_lo_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= tlic_pkg::ST_IDLE;
            cnt_r    <= '0;
            act_lo_r <= 1'b0;
            act_hi_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            act_lo_r <= act_lo_nxt;
            act_hi_r <= act_hi_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vec_r      <= tlic_pkg::RESET_VECTOR;
            lvl_r      <= 1'b1;
            cur_slot_r <= '0;
        end else if (take) begin
            vec_r      <= win_vector;
            lvl_r      <= win_high;
            cur_slot_r <= win_slot;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            long_call_instr_r <= 1'b0;
        end else begin
            long_call_instr_r <= call_end;
        end
    end

    // Cycles from detection to the start of the call, stalls included.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= '0;
            lat_r  <= '0;
        end else if (take) begin
            wait_r <= '0;
            lat_r  <= wait_r + 8'h01;
        end else if (win_valid && wait_r != 8'hff) begin
            wait_r <= wait_r + 8'h01;
        end else if (!win_valid) begin
            wait_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags and configuration.

    // Hardware events win over a software clear in the same cycle.
    assign pend_nxt = (((wr_pend ? wdata_slots : pend_r) & ~hw_clr)
                       | src_event) & tlic_pkg::SRC_MAP;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= tlic_pkg::PEND_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            global_irq_enable_r <= tlic_pkg::GEN_RST;
            enable_r            <= tlic_pkg::ENABLE_RST;
            prio_r              <= tlic_pkg::PRIO_RST;
        end else begin
            if (wr_ctrl) begin
                global_irq_enable_r <= reg_wdata[tlic_pkg::CTRL_GEN_BIT];
            end
            if (wr_enable) begin
                enable_r <= wdata_slots;
            end
            if (wr_prio) begin
                prio_r <= wdata_slots;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt output.

    logic [2:0] evt_set;

    assign evt_set[tlic_pkg::EVT_CALL_BIT] = call_end;
    assign evt_set[tlic_pkg::EVT_RET_BIT]  = ret_now;
    assign evt_set[tlic_pkg::EVT_NEST_BIT] = take && act_lo_r;
    assign evt_nxt = (evt_r & ~(wr_evt ? reg_wdata[2:0] : 3'h0)) | evt_set;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_r    <= tlic_pkg::EVT_RST;
            evmask_r <= tlic_pkg::EVMASK_RST;
        end else begin
            evt_r <= evt_nxt;
            if (wr_evmask) begin
                evmask_r <= reg_wdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [31:0] state_word;
    logic [31:0] rd_mux;

    assign state_word = {18'h00000, cur_slot_r, win_slot,
                         win_valid, state_r == tlic_pkg::ST_CALL,
                         act_hi_r, act_lo_r};

    assign rd_mux = sel_ctrl   ? {31'h0, global_irq_enable_r} :
                    sel_enable ? {13'h0, enable_r} :
                    sel_prio   ? {13'h0, prio_r} :
                    sel_pend   ? {13'h0, pend_r} :
                    sel_state  ? state_word :
                    sel_evt    ? {29'h0, evt_r} :
                    sel_evmask ? {29'h0, evmask_r} :
                    sel_lat    ? {24'h0, lat_r} :
                                 32'h0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata       = rdata_r;
    assign call_busy       = state_r == tlic_pkg::ST_CALL;
    assign long_call_instr = long_call_instr_r;
    assign call_vector     = vec_r;
    assign call_level      = lvl_r;
    assign irq_out         = |(evt_r & evmask_r);

endmodule

/* pkg/tlic_pkg.sv */
package tlic_pkg;

    localparam int          NUM_SLOTS     = 19;
    localparam int          SLOT_W        = 5;
    // Slots that own a real source; reserved slots are never requested.
    localparam logic [18:0] SRC_MAP       = 19'h5c9ff;
    // Sources whose pending flag is cleared when the call is made.
    localparam logic [18:0] HW_CLEAR_MAP  = 19'h0000f;

    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam int          VEC_SHIFT     = 3;

    localparam int          DETECT_CYCLES = 1;
    localparam int          CALL_CYCLES   = 5;

    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_ENABLE    = 8'h04;
    localparam logic [7:0]  OFS_PRIO      = 8'h08;
    localparam logic [7:0]  OFS_PEND      = 8'h0c;
    localparam logic [7:0]  OFS_STATE     = 8'h10;
    localparam logic [7:0]  OFS_EVT       = 8'h14;
    localparam logic [7:0]  OFS_EVMASK    = 8'h18;
    localparam logic [7:0]  OFS_LAT       = 8'h1c;

    localparam int          CTRL_GEN_BIT  = 0;
    localparam int          EVT_CALL_BIT  = 0;
    localparam int          EVT_RET_BIT   = 1;
    localparam int          EVT_NEST_BIT  = 2;
    localparam int          EVT_W         = 3;

    localparam logic        GEN_RST       = 1'b0;
    localparam logic [18:0] ENABLE_RST    = 19'h00000;
    localparam logic [18:0] PRIO_RST      = 19'h00000;
    localparam logic [18:0] PEND_RST      = 19'h00000;
    localparam logic [2:0]  EVT_RST       = 3'h0;
    localparam logic [2:0]  EVMASK_RST    = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALL = 3'b010,
        ST_RETH = 3'b100
    } tlic_state_t;

endpackage

/* verification/tb_two_level_interrupt_controller.sv */
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_two_level_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [18:0] src_event = 19'h00000;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, ret_cmd = 1'b0, stall_cmd = 1'b0;
    logic [3:0]  instr_len = 4'h1;
    logic        instr_done, return_from_service, core_stall, call_busy, long_call_instr, call_level, irq_out;
    logic [31:0] reg_rdata;
    logic [15:0] call_vector;
    int          n_fail = 0, cmp_count = 0, cyc = 0, b, l, c0;
    logic        irq_a;

    tlic_ctrl i_tlic_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .src_event(src_event), .instr_done(instr_done),
        .return_from_service(return_from_service), .core_stall(core_stall), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .call_busy(call_busy),
        .long_call_instr(long_call_instr), .call_vector(call_vector), .call_level(call_level), .irq_out(irq_out));
    tlic_core_model i_tlic_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .call_busy(call_busy),
        .long_call_instr(long_call_instr), .ret_cmd(ret_cmd), .stall_cmd(stall_cmd), .instr_len(instr_len),
        .instr_done(instr_done), .return_from_service(return_from_service), .core_stall(core_stall));
    ////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    function automatic logic [15:0] vec(input int s);
        return tlic_pkg::VEC_BASE + (16'(s) << tlic_pkg::VEC_SHIFT);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, ex, reg_rdata)
    endtask
    task automatic wait_call(input logic [15:0] v, input logic lv, input int lim, output int bz, output int n);
        bz = 0;
        for (n = 0; n < lim; n++) begin
            @(posedge clk_sys);
            #1;
            if (long_call_instr === 1'b1) break;
            if (call_busy === 1'b1) bz++;
        end
        `CHK("call_seen", 1'b1, long_call_instr)
        `CHK("call_vector", v, call_vector)
        `CHK("call_level", lv, call_level)
    endtask
    task automatic no_call(input int lim);
        repeat (lim) begin
            @(posedge clk_sys);
            #1;
            `CHK("no_call", 1'b0, call_busy)
        end
    endtask
    task automatic do_ret(output int c);
        @(posedge clk_sys);
        ret_cmd <= 1'b1;
        @(posedge clk_sys);
        ret_cmd <= 1'b0;
        for (int n = 0; n < 20 && return_from_service !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        c = cyc;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(tlic_pkg::OFS_CTRL, 32'h0, "ctrl");
        rd(tlic_pkg::OFS_ENABLE, 32'h0, "enable");
        rd(tlic_pkg::OFS_PRIO, 32'h0, "prio");
        rd(tlic_pkg::OFS_PEND, 32'h0, "pend");
        rd(8'h20, 32'h0, "unmapped");
        `CHK("reset_vector", tlic_pkg::RESET_VECTOR, call_vector)
    endtask
    task automatic t_fast();
        wr(tlic_pkg::OFS_CTRL, 32'h1);
        wr(tlic_pkg::OFS_ENABLE, 32'h7ffff);
        for (int s = 0; s < tlic_pkg::NUM_SLOTS; s++) begin
            if (tlic_pkg::SRC_MAP[s]) begin
                @(posedge clk_sys);
                src_event <= 19'h1 << s;
                @(posedge clk_sys);
                src_event <= 19'h0;
                wait_call(vec(s), 1'b0, 30, b, l);
                `CHK("busy_cycles", tlic_pkg::CALL_CYCLES, b)
                `CHK("latency", tlic_pkg::DETECT_CYCLES + tlic_pkg::CALL_CYCLES, l)
                wr(tlic_pkg::OFS_PEND, 32'h0);
                do_ret(c0);
            end
        end
        @(posedge clk_sys);
        src_event <= ~tlic_pkg::SRC_MAP;
        @(posedge clk_sys);
        src_event <= 19'h0;
        no_call(10);
        rd(tlic_pkg::OFS_PEND, 32'h0, "reserved_pend");
    endtask
    task automatic t_global();
        wr(tlic_pkg::OFS_EVT, 32'h7);
        wr(tlic_pkg::OFS_CTRL, 32'h0);
        wr(tlic_pkg::OFS_PEND, 32'h40);
        no_call(10);
        wr(tlic_pkg::OFS_CTRL, 32'h1);
        wait_call(vec(6), 1'b0, 30, b, l);
        wr(tlic_pkg::OFS_PEND, 32'h0);
        do_ret(c0);
        rd(tlic_pkg::OFS_EVT, 32'h3, "events");
        wr(tlic_pkg::OFS_EVMASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        irq_a = irq_out;
        wr(tlic_pkg::OFS_EVMASK, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("irq_mask_effect", 1'b1, irq_a ^ irq_out)
        wr(tlic_pkg::OFS_EVT, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("irq_cleared", 1'b0, irq_out)
    endtask
    task automatic t_order();
        wr(tlic_pkg::OFS_PRIO, 32'h100);
        wr(tlic_pkg::OFS_PEND, 32'h124);
        wait_call(vec(8), 1'b1, 30, b, l);
        wr(tlic_pkg::OFS_PEND, 32'h24);
        no_call(10);
        do_ret(c0);
        wait_call(vec(2), 1'b0, 30, b, l);
        no_call(10);
        wr(tlic_pkg::OFS_PRIO, 32'h80);
        wr(tlic_pkg::OFS_PEND, 32'ha0);
        wait_call(vec(7), 1'b1, 30, b, l);
        wr(tlic_pkg::OFS_PEND, 32'h20);
        do_ret(c0);
        no_call(10);
        do_ret(c0);
        wait_call(vec(5), 1'b0, 30, b, l);
        wr(tlic_pkg::OFS_PEND, 32'h0);
        wr(tlic_pkg::OFS_PRIO, 32'h0);
        rd(tlic_pkg::OFS_EVT, 32'h7, "evt");
        do_ret(c0);
    endtask
    task automatic t_stall();
        wr(tlic_pkg::OFS_PEND, 32'h10);
        for (int n = 0; n < 20 && call_busy !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        c0 = cyc;
        repeat (4) @(posedge clk_sys);
        stall_cmd <= 1'b1;
        repeat (3) @(posedge clk_sys);
        stall_cmd <= 1'b0;
        wait_call(vec(4), 1'b0, 30, b, l);
        `CHK("stalled_call", tlic_pkg::CALL_CYCLES + 3, cyc - c0)
        wr(tlic_pkg::OFS_PEND, 32'h0);
        do_ret(c0);
    endtask
    task automatic t_return();
        @(posedge clk_sys);
        instr_len <= 4'h8;
        wr(tlic_pkg::OFS_PEND, 32'h10);
        wait_call(vec(4), 1'b0, 60, b, l);
        do_ret(c0);
        wait_call(vec(4), 1'b0, 40, b, l);
        `CHK("return_latency", 8 + 1 + tlic_pkg::CALL_CYCLES, cyc - c0)
        instr_len <= 4'h1;
        wr(tlic_pkg::OFS_PEND, 32'h0);
        do_ret(c0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_fast();
        t_global();
        t_order();
        t_stall();
        t_return();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end
endmodule

bind tlic_ctrl tlic_checker i_tlic_checker (.clk_sys(clk_sys), .rst_n(rst_n), .src_event(src_event),
    .instr_done(instr_done), .return_from_service(return_from_service), .core_stall(core_stall),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .call_busy(call_busy), .long_call_instr(long_call_instr), .call_vector(call_vector),
    .call_level(call_level), .irq_out(irq_out));

/* verification/tlic_checker.sv */
module tlic_checker (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [18:0] src_event,
    input  wire logic        instr_done,
    input  wire logic        return_from_service,
    input  wire logic        core_stall,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        call_busy,
    input  wire logic        long_call_instr,
    input  wire logic [15:0] call_vector,
    input  wire logic        call_level,
    input  wire logic        irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busy_cnt_r;
    logic       stall_seen_r;
    logic       hi_run_r;
    logic       after_ret_r;
    logic [1:0] depth_r;
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Tracks call length, routine nesting and the gap after each return.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_r   <= 4'h0;
            stall_seen_r <= 1'b0;
            hi_run_r     <= 1'b0;
            after_ret_r  <= 1'b0;
            depth_r      <= 2'h0;
        end else begin
            busy_cnt_r   <= call_busy ? busy_cnt_r + 4'h1 : 4'h0;
            stall_seen_r <= call_busy && (stall_seen_r || core_stall);
            hi_run_r     <= (hi_run_r && !return_from_service) || (long_call_instr && call_level);
            after_ret_r  <= return_from_service || (after_ret_r && !(instr_done && !core_stall));
            if (long_call_instr) begin
                depth_r <= depth_r + 2'h1;
            end else if (return_from_service && depth_r != 2'h0) begin
                depth_r <= depth_r - 2'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    busy_len_a: assert property (long_call_instr && !stall_seen_r |-> busy_cnt_r == 4'h5)
        else $error("call length differs from five cycles");
    call_end_a: assert property ($fell(call_busy) |-> long_call_instr)
        else $error("call ended without the jump pulse");
    pulse_one_a: assert property (long_call_instr |=> !long_call_instr)
        else $error("jump pulse longer than one cycle");
    take_edge_a: assert property ($rose(call_busy) |-> $past(instr_done) && !$past(core_stall)
        && !$past(return_from_service))
        else $error("call started off an instruction boundary");
    vec_slot_a: assert property (long_call_instr |-> call_vector[2:0] == 3'h3 && call_vector[15:8] == 8'h00
        && tlic_pkg::SRC_MAP[call_vector[7:3]])
        else $error("vector not of a real source slot");
    hi_block_a: assert property (hi_run_r |-> !$rose(call_busy))
        else $error("high routine was preempted");
    nest_one_a: assert property ($rose(call_busy) |-> depth_r < 2'h2)
        else $error("nesting deeper than one level");
    ret_gap_a: assert property (after_ret_r |-> !$rose(call_busy))
        else $error("call taken before one instruction after return");
    stall_hold_a: assert property (call_busy && core_stall |=> call_busy)
        else $error("call finished during a stall");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read cycle");
endmodule

/* verification/tlic_core_model.sv */
module tlic_core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       call_busy,
    input  wire logic       long_call_instr,
    input  wire logic       ret_cmd,
    input  wire logic       stall_cmd,
    input  wire logic [3:0] instr_len,
    output logic            instr_done,
    output logic            return_from_service,
    output logic            core_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic       ret_pend_r;
    ////////////////////////////////////////////////////////////
    assign core_stall = stall_cmd;
    // Instructions of instr_len cycles; nothing completes while stalled or calling.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r               <= 4'h1;
            ret_pend_r          <= 1'b0;
            instr_done          <= 1'b0;
            return_from_service <= 1'b0;
        end else begin
            instr_done          <= 1'b0;
            return_from_service <= 1'b0;
            if (ret_cmd) begin
                ret_pend_r <= 1'b1;
            end
            if (!(stall_cmd || call_busy || long_call_instr)) begin
                if (ret_pend_r) begin
                    return_from_service <= 1'b1;
                    ret_pend_r          <= 1'b0;
                    cnt_r               <= 4'h1;
                end else if (cnt_r >= instr_len) begin
                    instr_done <= 1'b1;
                    cnt_r      <= 4'h1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule
